// File: slf_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far end: loops frames back, prompt (1 cycle) or slow (3)
module slf_far_end
  import slf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire slf_frame_t tx_frame_a,
  input wire slf_frame_t tx_frame_b,
  input wire logic tx_valid,
  input wire logic slow,
  input wire logic bad_nib,
  input wire logic fill_nib,
  output slf_frame_t rx_frame_a,
  output slf_frame_t rx_frame_b,
  output logic rx_valid_in
);
  slf_frame_t fa, fb, qa0, qa1, qb0, qb1;
  logic [1:0] qv;
  // only a first field is spoilt, on command of the bench
  always_comb begin
    fa = tx_frame_a;
    fb = tx_frame_b;
    if (bad_nib && !fa.nib[0]) begin
      fa.nib[2] = fa.nib[1];
      fb.nib[2] = fb.nib[1];
    end
    if (fill_nib && !fa.nib[0]) begin
      fa.nib[3] = 1'b1;
      fb.nib[3] = 1'b1;
    end
  end
  // frames move whole and in order, so slot positions survive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      qv <= 2'h0;
      rx_valid_in <= 1'b0;
      rx_frame_a <= '0;
      rx_frame_b <= '0;
    end else begin
      qv <= {qv[0], tx_valid};
      qa0 <= fa;
      qa1 <= qa0;
      qb0 <= fb;
      qb1 <= qb0;
      rx_valid_in <= slow ? qv[1] : tx_valid;
      // idle lines toggle so a stale value never passes as data
      if (slow ? qv[1] : tx_valid) begin
        rx_frame_a <= slow ? qa1 : fa;
        rx_frame_b <= slow ? qb1 : fb;
      end else begin
        rx_frame_a <= ~rx_frame_a;
        rx_frame_b <= ~rx_frame_b;
      end
    end
  end
endmodule
`default_nettype wire

// File: slf_framer.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - frames are 24 bits: 20-bit data field then a 4-bit coding nibble
// - nibble carries inversion, fill and flag, and the master transition
// - nibble bits one and two always differ on transmit, except link b frames in 32-bit use, which are all zero
// - side-signal slot position runs over 16 frames
// - each word splits into two fields; receive joins them back
// - connect, ready and overhead share the two side bits
// - eight overhead bits sent; the last alternates for framing
// - source words are taken on the source clock rising edge
// - interconnect signals are never carried over the link
// - forward data plus return connect/ready share link a; link b sends zero side bits
// - simplex zeroes reverse signals; recovered clock drives source clock
// - 32-bit uses link a; 64-bit adds link b in step
// - serial stream runs at 1.2 GBaud per link
// - no error correction or check code in the link layer
// - flag zero field goes out before flag one field
// - each connect/ready sample is sent in three frames alike
module slf_framer
  import slf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic src_clk,
  input wire slf_word_t src_word,
  input wire logic dst_connect,
  input wire logic dst_ready,
  input wire logic [7:1] oh_in,
  input wire logic simplex_en,
  input wire logic wide64_en,
  output slf_frame_t tx_frame_a,
  output slf_frame_t tx_frame_b,
  output logic tx_valid,
  input wire slf_frame_t rx_frame_a,
  input wire slf_frame_t rx_frame_b,
  input wire logic rx_valid_in,
  output slf_word_t rx_word,
  output logic rx_word_valid,
  output logic rx_connect,
  output logic rx_ready,
  output logic [8:1] rx_oh,
  output logic rx_align_err,
  output logic src_clk_out
);

  // ==========================================================
  // helpers
  function automatic logic [39:0] split_word(input logic [39:0] x);
    logic [39:0] y;
    y = '0;
    for (int i = 0; i < 40; i++) begin
      y[i] = x[SLF_MAP[i]];
    end
    return y;
  endfunction

  function automatic logic [39:0] join_word(input logic [39:0] y);
    logic [39:0] x;
    x = '0;
    for (int i = 0; i < 40; i++) begin
      x[SLF_MAP[i]] = y[i];
    end
    return x;
  endfunction

  function automatic logic [4:0] ones(input logic [19:0] f);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < FIELD_W; i++) begin
      n = n + 5'(f[i]);
    end
    return n;
  endfunction

  // invert heavy fields to keep the line near dc balance
  function automatic slf_frame_t make_frame(input logic [19:0] f,
                                            input logic flag);
    slf_frame_t fr;
    logic inv;
    inv = (ones(f) > 5'(BALANCE_MAX));
    fr.field = inv ? ~f : f;
    fr.nib[NIB_FLAG] = flag;
    fr.nib[NIB_NINV] = ~inv;
    fr.nib[NIB_INV] = inv;
    fr.nib[NIB_FILL] = 1'h0;
    return fr;
  endfunction

  function automatic logic [1:0] enc_ctl(input logic rq, input logic pk,
                                         input logic bu);
    if (rq && !pk && !bu) begin
      return 2'h1;
    end else if (rq && pk) begin
      return bu ? 2'h3 : 2'h2;
    end
    return 2'h0;
  endfunction

  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  // ==========================================================
  // synchronisers; no interconnect pins exist on this block
  logic clk_s1_r, clk_s2_r, clk_s3_r;
  slf_word_t wd_s1_r, wd_s2_r;
  logic [1:0] cr_s1_r, cr_s2_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_s1_r <= 1'h0;
      clk_s2_r <= 1'h0;
      clk_s3_r <= 1'h0;
      wd_s1_r <= '0;
      wd_s2_r <= '0;
      cr_s1_r <= 2'h0;
      cr_s2_r <= 2'h0;
    end else begin
      clk_s1_r <= src_clk;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      wd_s1_r <= src_word;
      wd_s2_r <= wd_s1_r;
      cr_s1_r <= {dst_connect, dst_ready};
      cr_s2_r <= cr_s1_r;
    end
  end

  // data is stable around the source edge, so both paths lag alike
  logic word_edge;
  assign word_edge = clk_s2_r & ~clk_s3_r;

  // ==========================================================
  // transmit: word splitter and side signal merger
  slf_tx_state_t tx_st_r, tx_st_nxt;
  slf_word_t wd_r, wd_nxt;
  logic [3:0] slot_r, slot_nxt;
  logic [1:0] cr_r, cr_nxt;
  logic oh8_r, oh8_nxt;
  slf_frame_t fa_r, fa_nxt, fb_r, fb_nxt;
  logic txv_r, txv_nxt;

  always_comb begin
    logic [39:0] la, lb;
    logic [1:0] ctl, cr_use;
    logic m0, m1;
    la = '0;
    lb = '0;
    ctl = 2'h0;
    cr_use = 2'h0;
    m0 = 1'h0;
    m1 = 1'h0;
    tx_st_nxt = tx_st_r;
    wd_nxt = wd_r;
    slot_nxt = slot_r;
    cr_nxt = cr_r;
    oh8_nxt = oh8_r;
    fa_nxt = fa_r;
    fb_nxt = fb_r;
    txv_nxt = 1'h0;
    // side bits for this word
    if (slot_r[1:0] == POS_OVERHEAD) begin
      m0 = (slot_r[3:2] == GRP_LAST) ? oh8_r : oh_in[5 + int'(slot_r[3:2])];
      m1 = oh_in[1 + int'(slot_r[3:2])];
    end else begin
      cr_use = (slot_r[1:0] == 2'h0) ? cr_s2_r : cr_r;
      cr_use = simplex_en ? 2'h0 : cr_use;
      m1 = cr_use[1];
      m0 = cr_use[0];
    end
    unique case (tx_st_r)
      TX_IDLE: begin
        if (word_edge) begin
          wd_nxt = wd_s2_r;
          ctl = enc_ctl(wd_s2_r.request, wd_s2_r.packet, wd_s2_r.burst);
          la = split_word({2'h0, ctl, wd_s2_r.par[3:0], wd_s2_r.data[31:0]});
          lb = split_word({2'h0, ctl, wd_s2_r.par[7:4],
                           wd_s2_r.data[63:32]});
          fa_nxt = make_frame(la[19:0], 1'h0);
          fb_nxt = wide64_en ? make_frame(lb[19:0], 1'h0) : '0;
          txv_nxt = 1'h1;
          tx_st_nxt = TX_SECOND;
        end
      end
      TX_SECOND: begin
        ctl = enc_ctl(wd_r.request, wd_r.packet, wd_r.burst);
        la = split_word({m1, m0, ctl, wd_r.par[3:0], wd_r.data[31:0]});
        lb = split_word({2'h0, ctl, wd_r.par[7:4], wd_r.data[63:32]});
        fa_nxt = make_frame(la[39:20], 1'h1);
        fb_nxt = wide64_en ? make_frame(lb[39:20], 1'h1) : '0;
        txv_nxt = 1'h1;
        cr_nxt = cr_use;
        if (slot_r == 4'(SLOT_FRAMES - 1)) begin
          oh8_nxt = ~oh8_r;
        end
        slot_nxt = slot_r + 4'h1;
        tx_st_nxt = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_r <= TX_IDLE;
      wd_r <= '0;
      slot_r <= SLOT_RESET;
      cr_r <= 2'h0;
      oh8_r <= OH8_RESET;
      fa_r <= '0;
      fb_r <= '0;
      txv_r <= 1'h0;
    end else begin
      tx_st_r <= tx_st_nxt;
      wd_r <= wd_nxt;
      slot_r <= slot_nxt;
      cr_r <= cr_nxt;
      oh8_r <= oh8_nxt;
      fa_r <= fa_nxt;
      fb_r <= fb_nxt;
      txv_r <= txv_nxt;
    end
  end

  // serializer outside runs each link at LINK_BAUD
  assign tx_frame_a = fa_r;
  assign tx_frame_b = fb_r;
  assign tx_valid = txv_r;

  // ==========================================================
  // receive: word joiner and side signal separator
  // the link carries no check code; parity rides through untouched
  logic have_r, have_nxt;
  logic [19:0] lo_a_r, lo_a_nxt, lo_b_r, lo_b_nxt;
  slf_word_t rw_r, rw_nxt;
  logic rwv_r, rwv_nxt, err_r, err_nxt;
  logic [3:0] rslot_r, rslot_nxt;
  logic [1:0] v0_r, v0_nxt, v1_r, v1_nxt, rcr_r, rcr_nxt;
  logic [8:1] roh_r, roh_nxt;
  logic rclk_r, rclk_nxt;

  always_comb begin
    logic [19:0] fa, fbf;
    logic [39:0] xa, xb;
    fa = rx_frame_a.nib[NIB_INV] ? ~rx_frame_a.field : rx_frame_a.field;
    fbf = rx_frame_b.nib[NIB_INV] ? ~rx_frame_b.field : rx_frame_b.field;
    xa = join_word({fa, lo_a_r});
    xb = join_word({fbf, lo_b_r});
    have_nxt = have_r;
    lo_a_nxt = lo_a_r;
    lo_b_nxt = lo_b_r;
    rw_nxt = rw_r;
    rwv_nxt = 1'h0;
    err_nxt = 1'h0;
    rslot_nxt = rslot_r;
    v0_nxt = v0_r;
    v1_nxt = v1_r;
    rcr_nxt = rcr_r;
    roh_nxt = roh_r;
    rclk_nxt = rclk_r;
    if (rx_valid_in) begin
      if (rx_frame_a.nib[NIB_NINV] == rx_frame_a.nib[NIB_INV]) begin
        err_nxt = 1'h1;
        have_nxt = 1'h0;
      end else if (!rx_frame_a.nib[NIB_FILL]) begin
        if (!rx_frame_a.nib[NIB_FLAG]) begin
          lo_a_nxt = fa;
          lo_b_nxt = fbf;
          have_nxt = 1'h1;
          rclk_nxt = 1'h0;
        end else if (have_r) begin
          have_nxt = 1'h0;
          rwv_nxt = 1'h1;
          rclk_nxt = 1'h1;
          rw_nxt.data = {wide64_en ? xb[31:0] : 32'h0, xa[31:0]};
          rw_nxt.par = {wide64_en ? xb[35:32] : 4'h0, xa[35:32]};
          rw_nxt.request = |xa[37:36];
          rw_nxt.packet = xa[37];
          rw_nxt.burst = &xa[37:36];
          rslot_nxt = rslot_r + 4'h1;
          unique case (rslot_r[1:0])
            2'h0: v0_nxt = xa[39:38];
            2'h1: v1_nxt = xa[39:38];
            2'h2: begin
              rcr_nxt = {maj3(v0_r[1], v1_r[1], xa[39]),
                         maj3(v0_r[0], v1_r[0], xa[38])};
            end
            2'h3: begin
              roh_nxt[5 + int'(rslot_r[3:2])] = xa[38];
              roh_nxt[1 + int'(rslot_r[3:2])] = xa[39];
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      have_r <= 1'h0;
      lo_a_r <= '0;
      lo_b_r <= '0;
      rw_r <= '0;
      rwv_r <= 1'h0;
      err_r <= 1'h0;
      rslot_r <= SLOT_RESET;
      v0_r <= 2'h0;
      v1_r <= 2'h0;
      rcr_r <= 2'h0;
      roh_r <= '0;
      rclk_r <= 1'h0;
    end else begin
      have_r <= have_nxt;
      lo_a_r <= lo_a_nxt;
      lo_b_r <= lo_b_nxt;
      rw_r <= rw_nxt;
      rwv_r <= rwv_nxt;
      err_r <= err_nxt;
      rslot_r <= rslot_nxt;
      v0_r <= v0_nxt;
      v1_r <= v1_nxt;
      rcr_r <= rcr_nxt;
      roh_r <= roh_nxt;
      rclk_r <= rclk_nxt;
    end
  end

  assign rx_word = rw_r;
  assign rx_word_valid = rwv_r;
  assign rx_connect = rcr_r[1] & ~simplex_en;
  assign rx_ready = rcr_r[0] & ~simplex_en;
  assign rx_oh = roh_r;
  assign rx_align_err = err_r;
  assign src_clk_out = rclk_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_MASTER_TRANS: assert property (
    tx_valid |-> tx_frame_a.nib[NIB_NINV] != tx_frame_a.nib[NIB_INV])
    else $error("master transition missing");
  AST_FLAG_ORDER: assert property (
    tx_valid && !tx_frame_a.nib[NIB_FLAG] |=>
      tx_valid && tx_frame_a.nib[NIB_FLAG])
    else $error("flag one field did not follow flag zero");
  AST_FLAG_ONE_CAUSE: assert property (
    tx_valid && tx_frame_a.nib[NIB_FLAG] |->
      $past(tx_valid) && !$past(tx_frame_a.nib[NIB_FLAG]))
    else $error("flag one field without first field");
  AST_BALANCE: assert property (
    tx_valid |-> ones(tx_frame_a.field) <= 5'(BALANCE_MAX))
    else $error("field not balanced");
  AST_TRIPLE: assert property (
    tx_st_r == TX_SECOND && slot_r[1:0] != 2'h0 &&
      slot_r[1:0] != POS_OVERHEAD |=>
      (tx_frame_a.field[M1_POS] ^ tx_frame_a.nib[NIB_INV]) == cr_r[1] &&
      (tx_frame_a.field[M0_POS] ^ tx_frame_a.nib[NIB_INV]) == cr_r[0])
    else $error("side sample changed within its three frames");
  AST_OH8_ALT: assert property (
    tx_st_r == TX_SECOND && slot_r == 4'(SLOT_FRAMES - 1) |=>
      oh8_r != $past(oh8_r))
    else $error("framing overhead bit did not alternate");
  AST_NARROW_B: assert property (
    !wide64_en && tx_valid |-> tx_frame_b == '0)
    else $error("link b active in 32-bit use");
  AST_RX_JOIN: assert property (
    rx_word_valid |-> $past(rx_valid_in) && $past(have_r))
    else $error("word joined without a field pair");
  AST_SIMPLEX: assert property (
    simplex_en |-> !rx_connect && !rx_ready)
    else $error("reverse signals active in simplex");
  AST_SIMPLEX_TX: assert property (
    simplex_en && tx_st_r == TX_SECOND && slot_r[1:0] != POS_OVERHEAD |=>
      (tx_frame_a.field[M1_POS] ^ tx_frame_a.nib[NIB_INV]) == 1'h0 &&
      (tx_frame_a.field[M0_POS] ^ tx_frame_a.nib[NIB_INV]) == 1'h0)
    else $error("reverse signals sent in simplex");

endmodule
`default_nettype wire

// File: slf_framer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module slf_framer_tb;
  import slf_pkg::*;
  logic core_clk, rst, src_clk, dst_connect, dst_ready, simplex_en;
  logic wide64_en, tx_valid, rx_valid_in, rx_word_valid, rx_connect;
  logic rx_ready, rx_align_err, src_clk_out, slow, bad_nib, c_s, r_s, oh8;
  logic fill_nib;
  logic [7:1] oh_in;
  logic [8:1] rx_oh;
  logic [75:0] e_rx;
  slf_word_t src_word, rx_word, w;
  slf_frame_t tx_frame_a, tx_frame_b, rx_frame_a, rx_frame_b;
  logic [75:0] exp_q [$];
  int bad_count = 0;
  int checked = 0;
  int wcount = 0;
  int err_cnt = 0;
  int cyc = 0;

  slf_framer dut_u (.core_clk(core_clk), .rst(rst), .src_clk(src_clk),
    .src_word(src_word), .dst_connect(dst_connect), .dst_ready(dst_ready),
    .oh_in(oh_in), .simplex_en(simplex_en), .wide64_en(wide64_en),
    .tx_frame_a(tx_frame_a), .tx_frame_b(tx_frame_b), .tx_valid(tx_valid),
    .rx_frame_a(rx_frame_a), .rx_frame_b(rx_frame_b),
    .rx_valid_in(rx_valid_in), .rx_word(rx_word),
    .rx_word_valid(rx_word_valid), .rx_connect(rx_connect),
    .rx_ready(rx_ready), .rx_oh(rx_oh), .rx_align_err(rx_align_err),
    .src_clk_out(src_clk_out));
  slf_far_end far_u (.core_clk(core_clk), .rst(rst),
    .tx_frame_a(tx_frame_a), .tx_frame_b(tx_frame_b), .tx_valid(tx_valid),
    .slow(slow), .bad_nib(bad_nib), .fill_nib(fill_nib),
    .rx_frame_a(rx_frame_a), .rx_frame_b(rx_frame_b),
    .rx_valid_in(rx_valid_in));

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [79:0] exp,
                     input logic [79:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [1:0] fcode(slf_word_t x);
    if (!x.request) return 2'h0;
    if (!x.packet) return x.burst ? 2'h0 : 2'h1;
    return x.burst ? 2'h3 : 2'h2;
  endfunction

  function automatic slf_frame_t exp_fr(slf_word_t x, bit hi, bit lb,
                                        logic m1, logic m0);
    logic [39:0] s;
    logic [19:0] f;
    logic inv;
    s = lb ? {2'h0, fcode(x), x.par[7:4], x.data[63:32]} :
             {m1, m0, fcode(x), x.par[3:0], x.data[31:0]};
    for (int i = 0; i < 20; i++) f[i] = s[SLF_MAP[i + 20 * hi]];
    inv = $countones(f) > BALANCE_MAX;
    return {1'b0, inv, ~inv, hi, inv ? ~f : f};
  endfunction

  // one word at a 400 ns source clock; rxchk: 0 none, 1 data, 2 link a
  task automatic send_word(input slf_word_t x, input int rxchk);
    slf_word_t d;
    logic m1, m0;
    logic [1:0] fc;
    int pos, n;
    pos = wcount % 16;
    if (pos % 4 == 0) begin
      c_s = dst_connect & ~simplex_en;
      r_s = dst_ready & ~simplex_en;
    end
    m1 = c_s;
    m0 = r_s;
    if (pos % 4 == 3) begin
      m1 = oh_in[1 + pos / 4];
      if (pos == 15) m0 = oh8;
      else m0 = oh_in[5 + pos / 4];
    end
    // receiver rebuilds the control lines from the code alone
    d = x;
    fc = fcode(x);
    {d.request, d.packet, d.burst} = {fc != 2'h0, fc[1], &fc};
    if (rxchk == 2) begin
      d.data[63:32] = '0;
      d.par[7:4] = '0;
    end
    if (rxchk > 0) exp_q.push_back({1'b1, d});
    @(posedge core_clk);
    src_word <= x;
    src_clk <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (tx_valid !== 1'b1 && n < 8);
    chk("frame a flag0", exp_fr(x, 0, 0, m1, m0), tx_frame_a);
    chk("frame b flag0", wide64_en ? exp_fr(x, 0, 1, 0, 0) : 0, tx_frame_b);
    @(posedge core_clk);
    src_clk <= 1'b0;
    #1;
    chk("tx_valid flag1", 1, tx_valid);
    chk("frame a flag1", exp_fr(x, 1, 0, m1, m0), tx_frame_a);
    chk("frame b flag1", wide64_en ? exp_fr(x, 1, 1, 0, 0) : 0, tx_frame_b);
    wcount++;
    if (pos == 15) oh8 = ~oh8;
    repeat (3) @(posedge core_clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_basic();
    w = '0;
    w.data = 64'hffff_ffff_ffff_fffe;
    w.par = 8'hff;
    send_word(w, 1);
    #1;
    chk("src_clk_out", 1, src_clk_out);
    slow <= 1'b1;
    w = '0;
    w.data = 64'h0000_0001_8000_0000;
    send_word(w, 1);
    send_word(~w, 1);
    slow <= 1'b0;
  endtask

  task automatic t_codes();
    for (int i = 0; i < 8; i++) begin
      w.data = 64'h0123_4567_89ab_cdef ^ 64'(i);
      w.par = 8'(i * 37);
      {w.request, w.packet, w.burst} = 3'(i);
      send_word(w, 1);
    end
  endtask

  task automatic t_narrow();
    @(posedge core_clk);
    wide64_en <= 1'b0;
    send_word(w, 2);
    wide64_en <= 1'b1;
  endtask

  task automatic t_slot(input logic sx, input logic cn, input logic rd,
                        input logic [7:1] oh);
    while (wcount % 16 != 0) send_word(w, 1);
    @(posedge core_clk);
    simplex_en <= sx;
    dst_connect <= cn;
    dst_ready <= rd;
    oh_in <= oh;
    // slot start must see the new levels, not the old ones
    @(posedge core_clk);
    for (int i = 0; i < 16; i++) send_word(w, 1);
    repeat (6) @(posedge core_clk);
    #1;
    chk("rx_connect", cn & ~sx, rx_connect);
    chk("rx_ready", rd & ~sx, rx_ready);
    chk("rx_oh", {~oh8, oh}, rx_oh);
  endtask

  task automatic t_align();
    int e;
    e = err_cnt;
    @(posedge core_clk);
    bad_nib <= 1'b1;
    send_word(w, 0);
    bad_nib <= 1'b0;
    chk("align errors", e + 1, err_cnt);
    @(posedge core_clk);
    fill_nib <= 1'b1;
    send_word(w, 0);
    fill_nib <= 1'b0;
    chk("align errors after fill", e + 1, err_cnt);
    send_word(~w, 1);
  endtask

  // ==========================================================
  // clock, receive monitor and cycle ceiling
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (rx_word_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unrequested rx word", 0, 1);
      end else begin
        e_rx = exp_q.pop_front();
        if (e_rx[75]) chk("rx word", e_rx[74:0], rx_word);
      end
    end
    if (rx_align_err === 1'b1) err_cnt++;
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    rst = 1'b1;
    src_clk = 1'b0;
    src_word = '0;
    dst_connect = 1'b0;
    dst_ready = 1'b0;
    oh_in = 7'h40;
    simplex_en = 1'b0;
    wide64_en = 1'b1;
    slow = 1'b0;
    bad_nib = 1'b0;
    fill_nib = 1'b0;
    c_s = 1'b0;
    r_s = 1'b0;
    oh8 = OH8_RESET;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_basic();
    t_codes();
    t_narrow();
    t_slot(1'b0, 1'b1, 1'b0, 7'h35);
    t_slot(1'b0, 1'b0, 1'b1, 7'h4a);
    t_slot(1'b1, 1'b1, 1'b1, 7'h7f);
    t_align();
    repeat (8) @(posedge core_clk);
    chk("words left in flight", 0, exp_q.size());
    final_report();
  end
endmodule
`default_nettype wire

// File: slf_pkg.sv
package slf_pkg;

  // ==========================================================
  // frame layout
  localparam int FIELD_W = 20;
  localparam int FRAME_W = 24;
  localparam int SLOT_FRAMES = 16;
  localparam int BALANCE_MAX = 10;
  localparam int NIB_FLAG = 0;
  localparam int NIB_NINV = 1;
  localparam int NIB_INV = 2;
  localparam int NIB_FILL = 3;
  localparam int M0_POS = 14;
  localparam int M1_POS = 19;
  localparam logic [1:0] POS_OVERHEAD = 2'h3;
  localparam logic [1:0] GRP_LAST = 2'h3;

  // ==========================================================
  // rates and reset values
  localparam int CORE_HZ = 20_000_000;
  localparam int LINK_BAUD = 1_200_000_000;
  localparam logic OH8_RESET = 1'h0;
  localparam logic [3:0] SLOT_RESET = 4'h0;

  // word bit i on the line (lo field 0..19, hi field 20..39) takes
  // bit SLF_MAP[i] of {m1,m0,f1,f0,par[3:0],data[31:0]}
  localparam int unsigned SLF_MAP [40] = '{
    0, 8, 16, 24, 1, 9, 17, 25, 2, 10, 18, 26, 3, 11, 36, 19, 27, 32, 33, 37,
    34, 35, 4, 12, 20, 28, 5, 13, 21, 29, 6, 14, 22, 30, 38, 7, 15, 23, 31, 39
  };

  typedef struct packed {
    logic [63:0] data;
    logic [7:0] par;
    logic request;
    logic packet;
    logic burst;
  } slf_word_t;

  typedef struct packed {
    logic [3:0] nib;
    logic [19:0] field;
  } slf_frame_t;

  typedef enum logic {TX_IDLE, TX_SECOND} slf_tx_state_t;

endpackage
